// file: hdl/hot_swap_regs.svh
// register offsets, field positions, reset values and timing counts of the buffer control
// Overview of operation
// - sides stay apart until start-up completes
// - supply lockout holds state, ignores lines
// - precharge on while locked out or starting up
// - after lockout watch backplane stop or idle
// - then require both card lines high
// - connect and enable boost together
// - ready only when enabled and connected
// - enable low disconnects, shuts everything down
// - enable high reruns start-up qualification
// - any low is mirrored to other side
// - owner side rises on its own release; a low still held on the other side is mirrored back after the guard
// - boost enabled on all pins once connected
// - relay keeps stretching and arbitration intact
// - ready follows stop after about 1.2 us
`ifndef HOT_SWAP_REGS_SVH
`define HOT_SWAP_REGS_SVH
`define CLK_PERIOD_NS    25
`define IDLE_TIME_US     95
`define IDLE_CYCLES      ((`IDLE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define STOP_DELAY_NS    1200
`define STOP_CYCLES      (`STOP_DELAY_NS / `CLK_PERIOD_NS)
`define GUARD_NS         200
`define GUARD_CYCLES     (`GUARD_NS / `CLK_PERIOD_NS)
`define IDLE_W           12
`define SETTLE_W         6
`define GUARD_W          4
`define PIN_BPD          0
`define PIN_BPC          1
`define PIN_CDD          2
`define PIN_CDC          3
`define PIN_EN           4
`define PIN_LOCK         5
`define PIN_RST          6'h2f
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_INT_STAT     8'h08
`define OFS_INT_MASK     8'h0c
`define OFS_IDLE_LIMIT   8'h10
`define CTRL_EN_BIT      0
`define CTRL_RST         1'h1
`define ST_READY_BIT     0
`define ST_LOCK_BIT      1
`define ST_SHUT_BIT      2
`define ST_CONN_BIT      3
`define EV_CONN          0
`define EV_DISC          1
`define EV_LOCK          2
`define EV_STOP          3
`define EV_W             4
`define HSIZE_WORD       3'h2
`endif

// file: hdl/hot_swap_pkg.sv
// state types of the hot-swap buffer control
package hot_swap_pkg;
  typedef enum logic [2:0] {LOCKOUT, WATCH, CARD_WAIT, SETTLE, CONNECTED, SHUTDOWN} conn_state_e;
  typedef enum logic [1:0] {OWN_NONE, OWN_BP, OWN_CARD} relay_owner_e;
endpackage : hot_swap_pkg

// file: hdl/hot_swap_two_wire_buffer_ctrl.sv
// start-up, relay, shutdown and register logic of the hot-swap two-wire buffer
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "hot_swap_regs.svh"

module hot_swap_two_wire_buffer_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        supply_lockout,
  input  wire logic        enable,
  input  wire logic        backplane_data_in,
  output logic             backplane_data_out,
  output logic             backplane_data_oe,
  input  wire logic        backplane_clock_in,
  output logic             backplane_clock_out,
  output logic             backplane_clock_oe,
  input  wire logic        card_data_in,
  output logic             card_data_out,
  output logic             card_data_oe,
  input  wire logic        card_clock_in,
  output logic             card_clock_out,
  output logic             card_clock_oe,
  output logic             precharge_en,
  output logic             boost_en,
  output logic             ready_out,
  output logic             ready_oe,
  output logic             irq,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [5:0]                   pin_raw;
  logic [5:0]                   sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  logic                         stop_q, stop_d;
  hot_swap_pkg::conn_state_e    state_q, state_d;
  logic [`IDLE_W-1:0]           idle_cnt_q, idle_cnt_d, idle_limit_q, idle_limit_d;
  logic [`SETTLE_W-1:0]         settle_cnt_q, settle_cnt_d;
  logic                         bus_hi, card_hi, idle_hit, en_eff, lock;
  logic                         precharge_q, precharge_d, boost_q, boost_d, ready_q, ready_d;
  logic                         zero_q, ready_oe_q;
  logic [3:0]                   line_oe;
  logic                         ctrl_en_q, ctrl_en_d;
  logic [`EV_W-1:0]             int_stat_q, int_stat_d, int_mask_q, int_mask_d, ev;
  logic                         irq_q, irq_d, wr_pend_q, wr_pend_d, take;
  logic [7:0]                   wr_addr_q, wr_addr_d;
  logic [31:0]                  hrdata_q, hrdata_d;
  logic                         hreadyout_q;

  // pin sampling: two flops, then a two-sample agreement filter
  assign pin_raw = {supply_lockout, enable, card_clock_in, card_data_in,
                    backplane_clock_in, backplane_data_in};

  always_comb begin
    filt_d = ((sync2_q ~^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
    stop_d = filt_d[`PIN_BPD] & ~filt_q[`PIN_BPD] & filt_q[`PIN_BPC] & filt_d[`PIN_BPC];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= `PIN_RST;
      sync2_q <= `PIN_RST;
      sync3_q <= `PIN_RST;
      filt_q  <= `PIN_RST;
      stop_q  <= 1'b0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
      stop_q  <= stop_d;
    end
  end

  a_stop_detect: assert property (stop_q |-> $past(filt_q[`PIN_BPC]) && filt_q[`PIN_BPD]
    && !$past(filt_q[`PIN_BPD])) else $error("stop flagged without data rise under clock high");

  // start-up qualification and connection state
  assign lock     = filt_q[`PIN_LOCK];
  assign en_eff   = filt_q[`PIN_EN] & ctrl_en_q;
  assign bus_hi   = filt_q[`PIN_BPD] & filt_q[`PIN_BPC];
  assign card_hi  = filt_q[`PIN_CDD] & filt_q[`PIN_CDC];
  assign idle_hit = bus_hi & (idle_cnt_q >= idle_limit_q);

  always_comb begin
    state_d      = state_q;
    settle_cnt_d = settle_cnt_q;
    idle_cnt_d   = '0;
    // idle time only counts once out of lockout and shutdown, so each start-up is fresh
    if (bus_hi && state_q != hot_swap_pkg::LOCKOUT && state_q != hot_swap_pkg::SHUTDOWN) begin
      idle_cnt_d = idle_hit ? idle_cnt_q : idle_cnt_q + `IDLE_W'(1);
    end
    if (lock) begin
      state_d = hot_swap_pkg::LOCKOUT;
    end else if (!en_eff) begin
      state_d = hot_swap_pkg::SHUTDOWN;
    end else begin
      unique case (state_q)
        hot_swap_pkg::LOCKOUT,
        hot_swap_pkg::SHUTDOWN: begin
          state_d = hot_swap_pkg::WATCH;
        end
        hot_swap_pkg::WATCH: begin
          if (stop_q || idle_hit) begin
            state_d = hot_swap_pkg::CARD_WAIT;
          end
        end
        hot_swap_pkg::CARD_WAIT: begin
          if (card_hi) begin
            state_d      = hot_swap_pkg::SETTLE;
            settle_cnt_d = '0;
          end
        end
        hot_swap_pkg::SETTLE: begin
          if (!card_hi) begin
            state_d = hot_swap_pkg::CARD_WAIT;
          end else if (settle_cnt_q == `SETTLE_W'(`STOP_CYCLES - 1)) begin
            state_d = hot_swap_pkg::CONNECTED;
          end else begin
            settle_cnt_d = settle_cnt_q + `SETTLE_W'(1);
          end
        end
        hot_swap_pkg::CONNECTED: begin
          state_d = hot_swap_pkg::CONNECTED;
        end
        default: begin
          state_d = hot_swap_pkg::LOCKOUT;
        end
      endcase
    end
    precharge_d = (state_d != hot_swap_pkg::CONNECTED) &&
                  (state_d != hot_swap_pkg::SHUTDOWN);
    boost_d     = (state_d == hot_swap_pkg::CONNECTED);
    ready_d     = (state_d == hot_swap_pkg::CONNECTED);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q      <= hot_swap_pkg::LOCKOUT;
      idle_cnt_q   <= '0;
      settle_cnt_q <= '0;
      precharge_q  <= 1'b1;
      boost_q      <= 1'b0;
      ready_q      <= 1'b0;
      ready_oe_q   <= 1'b1;
      zero_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      idle_cnt_q   <= idle_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      precharge_q  <= precharge_d;
      boost_q      <= boost_d;
      ready_q      <= ready_d;
      ready_oe_q   <= ~ready_d;
      zero_q       <= 1'b0;
    end
  end

  sequence s_settle_done;
    state_q == hot_swap_pkg::SETTLE && settle_cnt_q == `SETTLE_W'(`STOP_CYCLES - 1) && card_hi;
  endsequence

  sequence s_qualified;
    en_eff && !lock;
  endsequence

  a_lockout_hold: assert property (lock |=> state_q == hot_swap_pkg::LOCKOUT && !ready_q
    && precharge_q) else $error("lockout did not hold the block");
  a_ready_qualified: assert property (ready_q |-> state_q == hot_swap_pkg::CONNECTED
    && $past(en_eff)) else $error("ready without enable and connection");
  a_shutdown_entry: assert property (!en_eff && !lock |=> state_q == hot_swap_pkg::SHUTDOWN
    && !ready_q && !boost_q && !precharge_q) else $error("enable low did not shut down");
  a_settle_connect: assert property (s_settle_done ##0 s_qualified |=> ready_q && boost_q
    && !precharge_q) else $error("settled start-up did not connect");
  a_idle_advance: assert property (state_q == hot_swap_pkg::WATCH && idle_hit ##0 s_qualified
    |=> state_q == hot_swap_pkg::CARD_WAIT) else $error("idle backplane not accepted");
  a_card_gate: assert property (state_q == hot_swap_pkg::CARD_WAIT && !card_hi
    |=> state_q != hot_swap_pkg::SETTLE) else $error("settle entered with card low");
  a_precharge_pre: assert property (state_q == hot_swap_pkg::WATCH |-> precharge_q
    && !boost_q) else $error("precharge off before connection");

  // per pair relay: the side that pulls low first owns the pair until it lets go
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      hot_swap_pkg::relay_owner_e own_q, own_d;
      logic [`GUARD_W-1:0]        guard_q, guard_d;
      logic                       bp_oe_q, bp_oe_d, cd_oe_q, cd_oe_d, bp_lo, cd_lo;

      assign bp_lo = ~sync2_q[`PIN_BPD + p];
      assign cd_lo = ~sync2_q[`PIN_CDD + p];

      always_comb begin
        own_d   = own_q;
        guard_d = (guard_q != '0) ? guard_q - `GUARD_W'(1) : guard_q;
        if (state_q != hot_swap_pkg::CONNECTED) begin
          own_d   = hot_swap_pkg::OWN_NONE;
          guard_d = '0;
        end else begin
          unique case (own_q)
            hot_swap_pkg::OWN_NONE: begin
              if (guard_q == '0 && bp_lo) begin
                own_d = hot_swap_pkg::OWN_BP;
              end else if (guard_q == '0 && cd_lo) begin
                own_d = hot_swap_pkg::OWN_CARD;
              end
            end
            hot_swap_pkg::OWN_BP: begin
              if (!bp_lo) begin
                own_d   = hot_swap_pkg::OWN_NONE;
                guard_d = `GUARD_W'(`GUARD_CYCLES);
              end
            end
            hot_swap_pkg::OWN_CARD: begin
              if (!cd_lo) begin
                own_d   = hot_swap_pkg::OWN_NONE;
                guard_d = `GUARD_W'(`GUARD_CYCLES);
              end
            end
            default: begin
              own_d = hot_swap_pkg::OWN_NONE;
            end
          endcase
        end
        bp_oe_d = (own_d == hot_swap_pkg::OWN_CARD);
        cd_oe_d = (own_d == hot_swap_pkg::OWN_BP);
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          own_q   <= hot_swap_pkg::OWN_NONE;
          guard_q <= '0;
          bp_oe_q <= 1'b0;
          cd_oe_q <= 1'b0;
        end else begin
          own_q   <= own_d;
          guard_q <= guard_d;
          bp_oe_q <= bp_oe_d;
          cd_oe_q <= cd_oe_d;
        end
      end

      assign line_oe[`PIN_BPD + p] = bp_oe_q;
      assign line_oe[`PIN_CDD + p] = cd_oe_q;

      a_relay_low: assert property (state_q == hot_swap_pkg::CONNECTED && own_q ==
        hot_swap_pkg::OWN_NONE && guard_q == '0 && bp_lo ##1 state_q == hot_swap_pkg::CONNECTED
        |-> cd_oe_q) else $error("backplane low not mirrored to card");
      a_relay_release: assert property (own_q == hot_swap_pkg::OWN_BP && !bp_lo |=> !cd_oe_q
        [*2]) else $error("card side held low after backplane release");
    end
  endgenerate

  a_isolated_idle: assert property (state_q != hot_swap_pkg::CONNECTED |=> line_oe == '0)
    else $error("pins driven while disconnected");

  // register bus: zero-wait slave, writes land in the data phase
  assign take = hsel & htrans[1] & hready & (hsize == `HSIZE_WORD);
  assign ev[`EV_CONN] = (state_d == hot_swap_pkg::CONNECTED) && (state_q != hot_swap_pkg::CONNECTED);
  assign ev[`EV_DISC] = (state_d != hot_swap_pkg::CONNECTED) && (state_q == hot_swap_pkg::CONNECTED);
  assign ev[`EV_LOCK] = (state_d == hot_swap_pkg::LOCKOUT) && (state_q != hot_swap_pkg::LOCKOUT);
  assign ev[`EV_STOP] = stop_q;

  always_comb begin
    ctrl_en_d    = ctrl_en_q;
    int_mask_d   = int_mask_q;
    idle_limit_d = idle_limit_q;
    int_stat_d   = int_stat_q;
    wr_pend_d    = take & hwrite;
    wr_addr_d    = haddr[7:0];
    hrdata_d     = '0;
    if (wr_pend_q) begin
      unique case (wr_addr_q)
        `OFS_CTRL:       ctrl_en_d    = hwdata[`CTRL_EN_BIT];
        `OFS_INT_STAT:   int_stat_d   = int_stat_q & ~hwdata[`EV_W-1:0];
        `OFS_INT_MASK:   int_mask_d   = hwdata[`EV_W-1:0];
        `OFS_IDLE_LIMIT: idle_limit_d = hwdata[`IDLE_W-1:0];
        default: begin
        end
      endcase
    end
    int_stat_d = int_stat_d | ev; // a new event beats a same-cycle clear
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `OFS_CTRL:       hrdata_d[`CTRL_EN_BIT] = ctrl_en_q;
        `OFS_STATUS: begin
          hrdata_d[`ST_READY_BIT] = ready_q;
          hrdata_d[`ST_LOCK_BIT]  = (state_q == hot_swap_pkg::LOCKOUT);
          hrdata_d[`ST_SHUT_BIT]  = (state_q == hot_swap_pkg::SHUTDOWN);
          hrdata_d[`ST_CONN_BIT]  = (state_q == hot_swap_pkg::CONNECTED);
        end
        `OFS_INT_STAT:   hrdata_d[`EV_W-1:0]   = int_stat_q;
        `OFS_INT_MASK:   hrdata_d[`EV_W-1:0]   = int_mask_q;
        `OFS_IDLE_LIMIT: hrdata_d[`IDLE_W-1:0] = idle_limit_q;
        default: begin
        end
      endcase
    end
    irq_d = |(int_stat_q & int_mask_q);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_en_q    <= `CTRL_RST;
      int_stat_q   <= '0;
      int_mask_q   <= '0;
      idle_limit_q <= `IDLE_W'(`IDLE_CYCLES);
      wr_pend_q    <= 1'b0;
      wr_addr_q    <= '0;
      hrdata_q     <= '0;
      irq_q        <= 1'b0;
      hreadyout_q  <= 1'b1;
    end else begin
      ctrl_en_q    <= ctrl_en_d;
      int_stat_q   <= int_stat_d;
      int_mask_q   <= int_mask_d;
      idle_limit_q <= idle_limit_d;
      wr_pend_q    <= wr_pend_d;
      wr_addr_q    <= wr_addr_d;
      hrdata_q     <= hrdata_d;
      irq_q        <= irq_d;
      hreadyout_q  <= 1'b1;
    end
  end

  a_irq_level: assert property (irq_q == $past(|(int_stat_q & int_mask_q)))
    else $error("interrupt does not follow masked status");

  // pins and bus outputs straight from flops
  assign backplane_data_out  = zero_q;
  assign backplane_clock_out = zero_q;
  assign card_data_out       = zero_q;
  assign card_clock_out      = zero_q;
  assign ready_out           = zero_q;
  assign backplane_data_oe   = line_oe[`PIN_BPD];
  assign backplane_clock_oe  = line_oe[`PIN_BPC];
  assign card_data_oe        = line_oe[`PIN_CDD];
  assign card_clock_oe       = line_oe[`PIN_CDC];
  assign ready_oe            = ready_oe_q; // open drain: pulled low while not ready
  assign precharge_en        = precharge_q;
  assign boost_en            = boost_q;
  assign irq                 = irq_q;
  assign hrdata              = hrdata_q;
  assign hreadyout           = hreadyout_q;
  assign hresp               = zero_q;

endmodule : hot_swap_two_wire_buffer_ctrl

// file: sim/two_wire_side_model.sv
// behavioural bus devices and pull-ups on the backplane and card segments
`timescale 1ns/1ps

module two_wire_side_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] dut_pull,
  output logic      [3:0] line
);
  logic [3:0] hold_low_q = 4'h0;

  // wired-and of device and outside parties, pull-up level when all release
  assign line = ~(dut_pull | hold_low_q);

  // change one outside pull-down just after a clock edge
  task automatic pull(input int idx, input logic v);
    @(posedge core_clk);
    hold_low_q[idx] <= v;
  endtask : pull

  // start, nine clock pulses with data held low, then stop
  task automatic frame(input int half);
    pull(0, 1'b1);
    repeat (half) @(posedge core_clk);
    repeat (9) begin
      pull(1, 1'b1);
      repeat (half) @(posedge core_clk);
      pull(1, 1'b0);
      repeat (half) @(posedge core_clk);
    end
    pull(0, 1'b0);
  endtask : frame
endmodule : two_wire_side_model

// file: sim/tb.sv
// self-checking bench of the hot-swap buffer control
`timescale 1ns/1ps
`include "hot_swap_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module tb;
  logic        core_clk       = 1'b0;
  logic        rst            = 1'b1;
  logic        supply_lockout = 1'b1;
  logic        enable         = 1'b1;
  logic        hsel           = 1'b0;
  logic [31:0] haddr          = 32'h0;
  logic [1:0]  htrans         = 2'h0;
  logic        hwrite         = 1'b0;
  logic [2:0]  hsize          = 3'h2;
  logic [31:0] hwdata         = 32'h0;
  logic        clk_prev       = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  oe;
  logic [3:0]  line;
  logic        ready_oe;
  logic        boost_en;
  logic        precharge_en;
  logic        irq;
  logic [7:0]  mon;
  logic [31:0] d;
  int          fails          = 0;
  int          checked        = 0;
  int          falls          = 0;
  int          n;
  int          i;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  assign mon = {irq, precharge_en, boost_en, ready_oe, oe};

  // count falling edges of the card clock wire
  always @(posedge core_clk) begin
    clk_prev <= line[3];
    if (clk_prev && !line[3]) falls <= falls + 1;
  end

  hot_swap_two_wire_buffer_ctrl hot_swap_two_wire_buffer_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .supply_lockout(supply_lockout), .enable(enable),
    .backplane_data_in(line[0]), .backplane_data_out(), .backplane_data_oe(oe[0]),
    .backplane_clock_in(line[1]), .backplane_clock_out(), .backplane_clock_oe(oe[1]),
    .card_data_in(line[2]), .card_data_out(), .card_data_oe(oe[2]),
    .card_clock_in(line[3]), .card_clock_out(), .card_clock_oe(oe[3]),
    .precharge_en(precharge_en), .boost_en(boost_en), .ready_out(), .ready_oe(ready_oe),
    .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  two_wire_side_model two_wire_side_model_inst (
    .core_clk(core_clk), .dut_pull(oe), .line(line));

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // one single-word transfer, address phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    k = 0;
    do begin @(posedge core_clk); k++; end while (hreadyout !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hwdata <= v;
    do begin @(posedge core_clk); k++; end while (hreadyout !== 1'b1 && k < 40);
    d = hrdata;
    if (k >= 40) begin fails++; $display("BAD t=%0t bus %h exp %h", $time, k, 1); test_done(); end
    `CHK(hresp, 1'b0)
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(d, e)
  endtask : rd_chk

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc

  task automatic p(input int idx, input logic v);
    two_wire_side_model_inst.pull(idx, v);
  endtask : p

  // wait for one monitored output under a bound, counting cycles
  task automatic wait_sig(input int idx, input logic v, input int lim);
    n = 0;
    while (mon[idx] !== v && n < lim) begin @(posedge core_clk); n++; end
    if (mon[idx] !== v) begin fails++; $display("BAD t=%0t wait %h exp %h", $time, mon[idx], v); test_done(); end
  endtask : wait_sig

  // main sequence
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    `CHK(mon[6:0], 7'h50)
    cyc(8);
    rd_chk(`OFS_CTRL, 32'h1);
    rd_chk(`OFS_IDLE_LIMIT, 32'hed8);
    rd_chk(8'h20, 32'h0);
    rd_chk(`OFS_STATUS, 32'h2);
    wr(`OFS_STATUS, 32'hf);
    rd_chk(`OFS_STATUS, 32'h2);
    wr(`OFS_IDLE_LIMIT, 32'h14);
    rd_chk(`OFS_IDLE_LIMIT, 32'h14);
    $display("test registers done");
    p(0, 1'b1);
    cyc(200);
    `CHK(mon[6:0], 7'h50)
    p(2, 1'b1);
    @(posedge core_clk);
    supply_lockout <= 1'b0;
    cyc(100);
    `CHK(mon[6:0], 7'h50)
    p(0, 1'b0);
    cyc(200);
    `CHK(mon[6:4], 3'b101)
    p(2, 1'b0);
    wait_sig(4, 1'b0, 100);
    `CHK(mon[6:4], 3'b010)
    rd_chk(`OFS_STATUS, 32'h9);
    $display("test start-up done");
    for (i = 0; i < 4; i++) begin
      p(i, 1'b1);
      wait_sig(i ^ 2, 1'b1, 10);
      cyc(20);
      `CHK({line[i ^ 2], oe[i]}, 2'b00)
      p(i, 1'b0);
      wait_sig(i ^ 2, 1'b0, 10);
      cyc(12);
      `CHK(line, 4'hf)
    end
    p(2, 1'b1);
    cyc(10);
    p(0, 1'b1);
    cyc(10);
    p(2, 1'b0);
    cyc(20);
    `CHK(line[2], 1'b0)
    p(0, 1'b0);
    cyc(20);
    `CHK(line, 4'hf)
    n = falls;
    two_wire_side_model_inst.frame(50);
    cyc(20);
    `CHK(falls - n, 9)
    `CHK(mon[4], 1'b0)
    $display("test relay done");
    xfer(1'b0, `OFS_INT_STAT, 32'h0);
    `CHK(d[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(`OFS_INT_MASK, 32'h1);
    cyc(3);
    `CHK(irq, 1'b1)
    wr(`OFS_INT_STAT, 32'h1);
    cyc(3);
    `CHK(irq, 1'b0)
    xfer(1'b0, `OFS_INT_STAT, 32'h0);
    `CHK(d[0], 1'b0)
    $display("test interrupt done");
    @(posedge core_clk);
    enable <= 1'b0; // bus idle before shutdown
    wait_sig(4, 1'b1, 10);
    `CHK(mon[6:0], 7'h10)
    rd_chk(`OFS_STATUS, 32'h4);
    p(0, 1'b1);
    cyc(20);
    `CHK(mon[6:0], 7'h10)
    p(0, 1'b0);
    @(posedge core_clk);
    enable <= 1'b1;
    cyc(30);
    `CHK(mon[6:4], 3'b101)
    wait_sig(4, 1'b0, 120);
    `CHK(n + 30 >= 68, 1'b1)
    wr(`OFS_CTRL, 32'h0);
    cyc(10);
    `CHK(mon[6:4], 3'b001)
    p(0, 1'b1);
    wr(`OFS_CTRL, 32'h1);
    cyc(60);
    `CHK(mon[4], 1'b1)
    p(0, 1'b0);
    wait_sig(4, 1'b0, 80);
    `CHK(n >= 48 && n <= 64, 1'b1)
    $display("test shutdown done");
    @(posedge core_clk);
    supply_lockout <= 1'b1;
    wait_sig(4, 1'b1, 10);
    `CHK(mon[6:5], 2'b10)
    $display("test lockout done");
    test_done();
  end
endmodule : tb
